// *** hw/pcg_pkg.sv ***
// constants and types for the peripheral clock gating block
// assumes a 32-bit ahb-lite bus and one system clock
package pcg_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [31:0] PCG_BASE = 32'h400F_E000;
  localparam logic [11:0] PCG_OFS_CAP0 = 12'h010;
  localparam logic [11:0] PCG_OFS_CAP1 = 12'h014;
  localparam logic [11:0] PCG_OFS_RUN_CFG = 12'h060;
  localparam logic [11:0] PCG_OFS_RUN0 = 12'h100;
  localparam logic [11:0] PCG_OFS_RUN1 = 12'h104;
  localparam logic [11:0] PCG_OFS_SLP0 = 12'h110;
  localparam logic [11:0] PCG_OFS_SLP1 = 12'h114;
  localparam logic [11:0] PCG_OFS_DSL0 = 12'h120;
  localparam logic [11:0] PCG_OFS_DSL1 = 12'h124;
  localparam logic [11:0] PCG_OFS_INT_STAT = 12'h130;
  localparam logic [11:0] PCG_OFS_INT_MASK = 12'h134;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int PCG_BIT_CTRL_AREA_NET_UNIT0_GATE = 24;
  localparam int PCG_BIT_WDOG = 3;
  localparam int PCG_BIT_ACG = 27;
  localparam logic [31:0] PCG_IMPL_MASK0 = 32'h0100_0008;
  localparam logic [31:0] PCG_IMPL_MASK1 = 32'h0307_0011;
  localparam logic [31:0] PCG_CAP0_DEF = 32'h0100_709F;
  localparam logic [31:0] PCG_CAP1_DEF = 32'h0307_0011;
  localparam logic [31:0] PCG_GATE_RST = 32'h0000_0000;
  localparam int PCG_INT_W = 2;
  localparam int PCG_INT_FAULT = 0;
  localparam int PCG_INT_UNMAP = 1;
  localparam logic [PCG_INT_W-1:0] PCG_INT_RST = 2'h0;
  localparam int PCG_NSET = 6;
  localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PCG_MODE_RUN = 3'b001,
    PCG_MODE_SLEEP = 3'b010,
    PCG_MODE_DEEP = 3'b100
  } pcg_mode_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic [11:0] ofs;
  } pcg_addr_s;

endpackage : pcg_pkg

// *** hw/pcg_clock_gate.sv ***
// peripheral clock gating control with ahb-lite register slave
// assumes one clock, sleep requests from logic on the same clock
//
// How it works
// - a set gating bit drives its unit's clock enable high, a clear one holds it low.
// - an access to a unit whose clock enable is low is answered with a fault pulse.
// - all gating bits are zero after reset, so every gated unit starts unclocked.
// - each bank has a run set, a sleep set and a deep-sleep set of gating bits.
// - the sleep and deep-sleep sets apply only while the auto gating select bit is set.
// - in bank 0 bit 24 gates the can unit 0 and bit 3 the watchdog, both read-write.
// - bits naming no present unit never enable any clock.
// - bank 0 run, sleep and deep-sleep sets sit at offsets 0x100, 0x110 and 0x120.
// - all offsets are added to the system-control base 0x400F_E000.
// - bank 1 has its own three sets, its run set at offset 0x104.
// - capability words mask the gating bits so absent units stay at zero.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module pcg_clock_gate #(
  parameter logic [31:0] CAP0 = pcg_pkg::PCG_CAP0_DEF,
  parameter logic [31:0] CAP1 = pcg_pkg::PCG_CAP1_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sleep_req,
  input wire logic deepsleep_req,
  input wire logic periph_req,
  input wire logic [5:0] periph_unit,
  output logic periph_fault,
  output logic [31:0] unit_clk_en0,
  output logic [31:0] unit_clk_en1,
  output logic irq
);
  import pcg_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // index of gating set: set*2 + bank, or PCG_NSET when none
  function automatic logic [2:0] pcg_set_idx(input logic [11:0] ofs);
    logic [2:0] idx;
    idx = 3'(PCG_NSET);
    unique case (ofs)
      PCG_OFS_RUN0: idx = 3'd0;
      PCG_OFS_RUN1: idx = 3'd1;
      PCG_OFS_SLP0: idx = 3'd2;
      PCG_OFS_SLP1: idx = 3'd3;
      PCG_OFS_DSL0: idx = 3'd4;
      PCG_OFS_DSL1: idx = 3'd5;
      default: idx = 3'(PCG_NSET);
    endcase
    return idx;
  endfunction : pcg_set_idx

  // writable bits of a set: implemented and present in the part
  function automatic logic [31:0] pcg_wmask(input logic [2:0] idx);
    logic [31:0] m;
    m = idx[0] ? (PCG_IMPL_MASK1 & CAP1) : (PCG_IMPL_MASK0 & CAP0);
    return m;
  endfunction : pcg_wmask

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pcg_addr_s aph_ff;
  logic rd_wait_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] gate_ff [PCG_NSET];
  logic acg_ff;
  logic [PCG_INT_W-1:0] int_stat_ff;
  logic [PCG_INT_W-1:0] int_mask_ff;
  logic irq_ff;
  pcg_mode_e mode_ff;
  pcg_mode_e nxt_mode;
  logic [31:0] en0_ff;
  logic [31:0] en1_ff;
  logic periph_fault_ff;

  logic take;
  logic wr_do;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [PCG_INT_W-1:0] int_set;
  logic [PCG_INT_W-1:0] int_clr;
  logic [63:0] en_flat;
  logic [31:0] nxt_en0;
  logic [31:0] nxt_en1;
  logic [31:0] rd_val;

  assign take = hsel && hready && (htrans == PCG_HTRANS_NONSEQ);
  assign wr_do = aph_ff.valid && aph_ff.write && aph_ff.mapped;
  assign wr_idx = pcg_set_idx(aph_ff.ofs);
  assign rd_idx = pcg_set_idx(aph_ff.ofs);
  assign en_flat = {en1_ff, en0_ff};

  // ----------------------------------------------------------------
  // ahb-lite address phase
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aph_ff <= '0;
    end
    else if (clk_en)
    begin
      if (hready)
      begin
        aph_ff.valid <= take;
        aph_ff.write <= hwrite;
        aph_ff.mapped <= (haddr[31:12] == PCG_BASE[31:12]);
        aph_ff.ofs <= haddr[11:0];
      end
    end
  end

  // one wait state on reads so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'b1;
      rd_wait_ff <= 1'b0;
      hresp_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      hresp_ff <= 1'b0;
      if (take && !hwrite)
      begin
        hreadyout_ff <= 1'b0;
        rd_wait_ff <= 1'b1;
      end
      else if (rd_wait_ff)
      begin
        hreadyout_ff <= 1'b1;
        rd_wait_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (aph_ff.mapped)
    begin
      if (rd_idx < 3'(PCG_NSET))
      begin
        rd_val = gate_ff[rd_idx];
      end
      else
      begin
        unique case (aph_ff.ofs)
          PCG_OFS_CAP0: rd_val = CAP0;
          PCG_OFS_CAP1: rd_val = CAP1;
          PCG_OFS_RUN_CFG: rd_val[PCG_BIT_ACG] = acg_ff;
          PCG_OFS_INT_STAT: rd_val[PCG_INT_W-1:0] = int_stat_ff;
          PCG_OFS_INT_MASK: rd_val[PCG_INT_W-1:0] = int_mask_ff;
          default: rd_val = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (rd_wait_ff)
      begin
        hrdata_ff <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // gating sets
  // ----------------------------------------------------------------
  // reserved and absent bits are never stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < PCG_NSET; i++)
      begin
        gate_ff[i] <= PCG_GATE_RST;
      end
    end
    else if (clk_en)
    begin
      if (wr_do && (wr_idx < 3'(PCG_NSET)))
      begin
        gate_ff[wr_idx] <= hwdata & pcg_wmask(wr_idx);
      end
    end
  end

  // auto clock gating select
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acg_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_do && (aph_ff.ofs == PCG_OFS_RUN_CFG))
      begin
        acg_ff <= hwdata[PCG_BIT_ACG];
      end
    end
  end

  // ----------------------------------------------------------------
  // operating mode and clock enables
  // ----------------------------------------------------------------
  always_comb
  begin
    if (deepsleep_req)
    begin
      nxt_mode = PCG_MODE_DEEP;
    end
    else if (sleep_req)
    begin
      nxt_mode = PCG_MODE_SLEEP;
    end
    else
    begin
      nxt_mode = PCG_MODE_RUN;
    end
  end

  always_comb
  begin
    nxt_en0 = gate_ff[0];
    nxt_en1 = gate_ff[1];
    if (acg_ff)
    begin
      unique case (mode_ff)
        PCG_MODE_RUN:
        begin
          nxt_en0 = gate_ff[0];
          nxt_en1 = gate_ff[1];
        end
        PCG_MODE_SLEEP:
        begin
          nxt_en0 = gate_ff[2];
          nxt_en1 = gate_ff[3];
        end
        PCG_MODE_DEEP:
        begin
          nxt_en0 = gate_ff[4];
          nxt_en1 = gate_ff[5];
        end
        default:
        begin
          nxt_en0 = gate_ff[0];
          nxt_en1 = gate_ff[1];
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_ff <= PCG_MODE_RUN;
      en0_ff <= PCG_GATE_RST;
      en1_ff <= PCG_GATE_RST;
    end
    else if (clk_en)
    begin
      mode_ff <= nxt_mode;
      en0_ff <= nxt_en0 & PCG_IMPL_MASK0 & CAP0;
      en1_ff <= nxt_en1 & PCG_IMPL_MASK1 & CAP1;
    end
  end

  // ----------------------------------------------------------------
  // access check for gated units
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      periph_fault_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      periph_fault_ff <= periph_req && !en_flat[periph_unit];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  always_comb
  begin
    int_set = '0;
    int_set[PCG_INT_FAULT] = periph_req && !en_flat[periph_unit];
    int_set[PCG_INT_UNMAP] = take && !(haddr[31:12] == PCG_BASE[31:12]);
    int_clr = '0;
    if (wr_do && (aph_ff.ofs == PCG_OFS_INT_STAT))
    begin
      int_clr = hwdata[PCG_INT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_stat_ff <= PCG_INT_RST;
      int_mask_ff <= PCG_INT_RST;
      irq_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
      if (wr_do && (aph_ff.ofs == PCG_OFS_INT_MASK))
      begin
        int_mask_ff <= hwdata[PCG_INT_W-1:0];
      end
      irq_ff <= |(((int_stat_ff & ~int_clr) | int_set) & int_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign periph_fault = periph_fault_ff;
  assign unit_clk_en0 = en0_ff;
  assign unit_clk_en1 = en1_ff;
  assign irq = irq_ff;

endmodule : pcg_clock_gate

// *** bench/pcg_sva.sv ***
// assertion checker for the peripheral clock gating block
// assumes it is bound to pcg_clock_gate and sees only its ports
`timescale 1ns/100ps
module pcg_sva
  import pcg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic periph_req,
  input wire logic [5:0] periph_unit,
  input wire logic periph_fault,
  input wire logic [31:0] unit_clk_en0,
  input wire logic [31:0] unit_clk_en1
);
  logic en_sel;
  logic take;
  assign en_sel = periph_unit[5] ? unit_clk_en1[periph_unit[4:0]] : unit_clk_en0[periph_unit[4:0]];
  assign take = hsel && hready && htrans == PCG_HTRANS_NONSEQ && clk_en;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_fault_gated: assert property (periph_req && clk_en && !en_sel |=> periph_fault)
    else $error("fault missing");
  a_fault_none: assert property (periph_req && clk_en && en_sel |=> !periph_fault)
    else $error("fault on clocked unit");
  a_fault_cause: assert property (periph_fault |-> $past(periph_req))
    else $error("fault without access");
  a_reset_zero: assert property ($rose(hresetn) |-> unit_clk_en0 == 0 && unit_clk_en1 == 0)
    else $error("enables not zero after reset");
  a_resv_bank0: assert property ((unit_clk_en0 & ~PCG_IMPL_MASK0) == 0)
    else $error("reserved bank0 enable set");
  a_resv_bank1: assert property ((unit_clk_en1 & ~PCG_IMPL_MASK1) == 0)
    else $error("absent bank1 enable set");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
endmodule : pcg_sva
bind pcg_clock_gate pcg_sva u_sva (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .periph_req(periph_req), .periph_unit(periph_unit), .periph_fault(periph_fault),
  .unit_clk_en0(unit_clk_en0), .unit_clk_en1(unit_clk_en1));

// *** bench/pcg_unit_model.sv ***
// peripheral unit model: issues accesses to gated units
// assumes hclk is the system clock of the gating block
`timescale 1ns/100ps
module pcg_unit_model (
  input wire logic hclk,
  output logic periph_req,
  output logic [5:0] periph_unit
);
  initial
  begin
    periph_req = 1'b0;
    periph_unit = 6'h00;
  end
  // one access pulse, unit lines inverted once released
  task access(input logic [5:0] u);
    @(posedge hclk);
    periph_req <= 1'b1;
    periph_unit <= u;
    @(posedge hclk);
    periph_req <= 1'b0;
    periph_unit <= ~u;
  endtask : access
endmodule : pcg_unit_model

// *** bench/tb_peripheral_clock_gating.sv ***
// testbench for the peripheral clock gating block
// assumes one 25 mhz clock and a single ahb-lite slave
`timescale 1ns/100ps
module tb_peripheral_clock_gating;
  import pcg_pkg::*;
  localparam logic [11:0] OFS [6] = '{PCG_OFS_RUN0, PCG_OFS_SLP0, PCG_OFS_DSL0,
    PCG_OFS_RUN1, PCG_OFS_SLP1, PCG_OFS_DSL1};
  logic hclk, hresetn, clk_en, hsel, hwrite, hready, sleep_req, deepsleep_req;
  logic hreadyout, hresp, periph_req, periph_fault, irq, rd_dp, f_dp;
  logic [31:0] haddr, hwdata, hrdata, unit_clk_en0, unit_clk_en1, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] periph_unit;
  logic [31:0] exp_q[$];
  int num_errors, compares, cyc;
  assign hready = hreadyout;
  pcg_clock_gate dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sleep_req(sleep_req), .deepsleep_req(deepsleep_req), .periph_req(periph_req),
    .periph_unit(periph_unit), .periph_fault(periph_fault), .unit_clk_en0(unit_clk_en0),
    .unit_clk_en1(unit_clk_en1), .irq(irq));
  pcg_unit_model um (.hclk(hclk), .periph_req(periph_req), .periph_unit(periph_unit));
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // one single transfer, read data noted for the monitor
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= PCG_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    if (!w)
      exp_q.push_back(e);
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : bus
  task acc(input logic [5:0] u, input logic f);
    exp_q.push_back({31'h0, f});
    um.access(u);
  endtask : acc
  always @(posedge hclk)
  begin
    if (rd_dp && hreadyout)
    begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, 32'h0000_0000);
    end
    if (f_dp)
      check({31'h0, periph_fault}, exp_q.pop_front());
    rd_dp <= (hsel && hready && htrans == PCG_HTRANS_NONSEQ && !hwrite) || (rd_dp && !hreadyout);
    f_dp <= periph_req;
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  initial
  begin
    {hsel, hwrite, clk_en, sleep_req, deepsleep_req, hresetn, rd_dp, f_dp} = 8'h20;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    void'($urandom(41));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (OFS[i]) bus(1'b0, PCG_BASE + OFS[i], 0, 0);
    bus(1'b1, PCG_BASE + PCG_OFS_CAP0, 0, 0);
    bus(1'b0, PCG_BASE + PCG_OFS_CAP0, 0, PCG_CAP0_DEF);
    check(unit_clk_en0, 0);
    $display("test reset done");
    foreach (OFS[i])
    begin
      d = $urandom;
      bus(1'b1, PCG_BASE + OFS[i], d, 0);
      bus(1'b0, PCG_BASE + OFS[i], 0, d & (i < 3 ? PCG_IMPL_MASK0 : PCG_IMPL_MASK1));
    end
    $display("test sets done");
    bus(1'b1, PCG_BASE + PCG_OFS_RUN0, '1, 0);
    bus(1'b1, PCG_BASE + PCG_OFS_SLP0, 32'h0100_0000, 0);
    bus(1'b1, PCG_BASE + PCG_OFS_DSL0, 32'h0000_0008, 0);
    sleep_req <= 1'b1;
    repeat (3) @(posedge hclk);
    check(unit_clk_en0, PCG_IMPL_MASK0);
    bus(1'b1, PCG_BASE + PCG_OFS_RUN_CFG, 32'h0800_0000, 0);
    repeat (3) @(posedge hclk);
    check(unit_clk_en0, 32'h0100_0000);
    deepsleep_req <= 1'b1;
    repeat (3) @(posedge hclk);
    check(unit_clk_en0, 32'h0000_0008);
    acc(6'd24, 1'b1);
    acc(6'd3, 1'b0);
    clk_en <= 1'b0;
    {sleep_req, deepsleep_req} <= 2'b00;
    repeat (3) @(posedge hclk);
    check(unit_clk_en0, 32'h0000_0008);
    clk_en <= 1'b1;
    bus(1'b1, PCG_BASE + PCG_OFS_RUN_CFG, 0, 0);
    $display("test modes done");
    bus(1'b1, PCG_BASE + PCG_OFS_RUN1, '1, 0);
    repeat (3) @(posedge hclk);
    check(unit_clk_en1, PCG_IMPL_MASK1);
    acc(6'd32, 1'b0);
    bus(1'b0, PCG_BASE + PCG_OFS_RUN1, 0, PCG_IMPL_MASK1);
    bus(1'b1, PCG_BASE + PCG_OFS_RUN1, PCG_IMPL_MASK1 & ~32'h0000_0001, 0);
    repeat (3) @(posedge hclk);
    acc(6'd32, 1'b1);
    acc(6'd36, 1'b0);
    $display("test bank1 done");
    bus(1'b1, PCG_BASE + PCG_OFS_INT_STAT, 32'h3, 0);
    bus(1'b0, PCG_BASE + PCG_OFS_INT_STAT, 0, 32'h0);
    bus(1'b1, PCG_BASE + PCG_OFS_INT_MASK, 32'h3, 0);
    repeat (2) @(posedge hclk);
    check(irq, 0);
    acc(6'd5, 1'b1);
    bus(1'b0, PCG_BASE + PCG_OFS_INT_STAT, 0, 32'h1);
    check(irq, 1);
    bus(1'b1, PCG_BASE + PCG_OFS_INT_STAT, 32'h1, 0);
    bus(1'b1, 32'h4000_0100, '1, 0);
    bus(1'b0, PCG_BASE + PCG_OFS_INT_STAT, 0, 32'h2);
    bus(1'b1, PCG_BASE + PCG_OFS_INT_MASK, 0, 0);
    repeat (2) @(posedge hclk);
    check(irq, 0);
    $display("test irq done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, PCG_BASE + PCG_OFS_RUN0, 0, 0);
    check(unit_clk_en0, 0);
    check(irq, 0);
    $display("test reset again done");
    end_of_test();
  end
endmodule : tb_peripheral_clock_gating
